// file: ramp_id_pkg.sv
// Package with register offsets, reset values, field layouts and types of the register bank.
package ramp_id_pkg;
    localparam logic [7:0] OFS_EXT_CLOCK      = 8'h05;
    localparam logic [7:0] OFS_SLEW_CTRL      = 8'h06;
    localparam logic [7:0] OFS_DIE_KIND       = 8'h08;
    localparam logic [7:0] OFS_DIE_REVISION   = 8'h09;
    localparam logic [7:0] RST_EXT_CLOCK      = 8'h00;
    localparam logic [7:0] RST_SLEW_CTRL      = 8'h01;
    localparam int         POS_CLK_SEL        = 6;
    localparam int         POS_SLEW_RATE      = 5;
    localparam int         POS_PIN_PSAVE      = 4;
    localparam int         POS_KEEP_OSC       = 3;
    localparam int         POS_RAMP_DOWN      = 1;
    localparam int         POS_SLEW_RSVD_ONE  = 0;
    localparam logic [7:0] MASK_EXT_CLOCK     = 8'hC0;
    localparam logic [7:0] MASK_SLEW_CTRL     = 8'hFB;
    // Identification values; arbitrary neutral codes, not those of any real part.
    localparam logic [7:0] DIE_KIND_VALUE     = 8'h37;
    localparam logic [7:0] DIE_REVISION_VALUE = 8'h1C;

    // External clock frequency selection.
    typedef enum logic [1:0] {
        CLK_26MHZ,
        CLK_13MHZ,
        CLK_19M2HZ
    } ext_clk_freq_t;

    // Register write request.
    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_wr_t;

    // Controls handed to the converter core.
    typedef struct packed {
        ext_clk_freq_t clk_freq;
        logic [2:0]    slew_code;
        logic          power_save_only;
        logic          osc_on;
        logic          crossing_det_off;
        logic          pwm_forced;
        logic          follow_ext_clock;
    } conv_ctrl_t;
endpackage

// file: regulator_sync_ramp_id_regs.sv
// Register bank for external clock select, slew/power-save control and die identification.
`timescale 1ns/100ps
`default_nettype none
module regulator_sync_ramp_id_regs
    import ramp_id_pkg::*;
(
    // Clock and reset.
    input  wire logic                    clk_sys_in,
    input  wire logic                    arst_n_in,
    // Supply monitor levels from the analog side.
    input  wire logic                    vdd_undervoltage_lockout_in,
    input  wire logic                    main_input_supply_undervoltage_lockout_in,
    // Register port from the two-wire protocol engine.
    input  wire ramp_id_pkg::reg_wr_t    reg_wr_in,
    input  wire logic [7:0]              rd_addr_in,
    output logic [7:0]                   rd_data_out,
    // Converter state and per-mode bits.
    input  wire logic                    hysteretic_active_in,
    input  wire logic                    ramping_down_in,
    input  wire logic                    operation_mode_in,
    input  wire logic                    ext_clock_follow_enable_in,
    // Controls to the converter.
    output ramp_id_pkg::conv_ctrl_t      conv_ctrl_out
);
    import ramp_id_pkg::*;

    logic [7:0] ext_clock_ff;
    logic [7:0] slew_ctrl_ff;
    logic [7:0] nxt_ext_clock;
    logic [7:0] nxt_slew_ctrl;
    logic [7:0] nxt_rd_data;
    logic       undervoltage_lockout_s1_ff;
    logic       undervoltage_lockout_s2_ff;
    logic       mode_s1_ff;
    logic       mode_s2_ff;
    logic       sync_s1_ff;
    logic       sync_s2_ff;
    logic       hys_s1_ff;
    logic       hys_s2_ff;
    logic       down_s1_ff;
    logic       down_s2_ff;
    logic [1:0] clk_sel;
    logic       power_save_only;

    // Analog-side levels are synchronised before use.
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            undervoltage_lockout_s1_ff <= 1'b1;
            undervoltage_lockout_s2_ff <= 1'b1;
            {mode_s1_ff, sync_s1_ff, hys_s1_ff, down_s1_ff} <= 4'h0;
            {mode_s2_ff, sync_s2_ff, hys_s2_ff, down_s2_ff} <= 4'h0;
        end else begin
            undervoltage_lockout_s1_ff <= vdd_undervoltage_lockout_in | main_input_supply_undervoltage_lockout_in;
            undervoltage_lockout_s2_ff <= undervoltage_lockout_s1_ff;
            {mode_s1_ff, sync_s1_ff, hys_s1_ff, down_s1_ff} <= {operation_mode_in,
                ext_clock_follow_enable_in, hysteretic_active_in, ramping_down_in};
            {mode_s2_ff, sync_s2_ff, hys_s2_ff, down_s2_ff} <= {mode_s1_ff, sync_s1_ff,
                hys_s1_ff, down_s1_ff};
        end
    end

    // Write decode; reserved bits are masked, bit 0 of slew control held at one.
    assign nxt_ext_clock = (reg_wr_in.wr_en && reg_wr_in.addr == OFS_EXT_CLOCK)
                         ? (reg_wr_in.wdata & MASK_EXT_CLOCK) : ext_clock_ff;
    assign nxt_slew_ctrl = (reg_wr_in.wr_en && reg_wr_in.addr == OFS_SLEW_CTRL)
                         ? ((reg_wr_in.wdata & MASK_SLEW_CTRL) | RST_SLEW_CTRL)
                         : slew_ctrl_ff;

    // Lockout returns both registers to their reset values.
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ext_clock_ff <= RST_EXT_CLOCK;
            slew_ctrl_ff <= RST_SLEW_CTRL;
        end else if (undervoltage_lockout_s2_ff) begin
            ext_clock_ff <= RST_EXT_CLOCK;
            slew_ctrl_ff <= RST_SLEW_CTRL;
        end else begin
            ext_clock_ff <= nxt_ext_clock;
            slew_ctrl_ff <= nxt_slew_ctrl;
        end
    end

    // Read mux; identification registers are constants, so writes cannot touch them.
    assign nxt_rd_data = (rd_addr_in == OFS_EXT_CLOCK)    ? ext_clock_ff :
                         (rd_addr_in == OFS_SLEW_CTRL)    ? slew_ctrl_ff :
                         (rd_addr_in == OFS_DIE_KIND)     ? DIE_KIND_VALUE :
                         (rd_addr_in == OFS_DIE_REVISION) ? DIE_REVISION_VALUE :
                         8'h00;

    // Read data is registered one cycle after the address.
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_data_out <= 8'h00;
        end else begin
            rd_data_out <= nxt_rd_data;
        end
    end

    // Converter controls decoded from the registers and mode bits.
    assign clk_sel         = ext_clock_ff[POS_CLK_SEL +: 2];
    assign power_save_only = slew_ctrl_ff[POS_PIN_PSAVE] & ~mode_s2_ff;
    always_comb begin
        unique case (clk_sel)
            2'h0:    conv_ctrl_out.clk_freq = CLK_26MHZ;
            2'h1:    conv_ctrl_out.clk_freq = CLK_13MHZ;
            default: conv_ctrl_out.clk_freq = CLK_19M2HZ;
        endcase
        conv_ctrl_out.slew_code        = slew_ctrl_ff[POS_SLEW_RATE +: 3];
        conv_ctrl_out.power_save_only  = power_save_only;
        conv_ctrl_out.osc_on           = ~hys_s2_ff | slew_ctrl_ff[POS_KEEP_OSC];
        conv_ctrl_out.crossing_det_off = ~mode_s2_ff & hys_s2_ff & down_s2_ff
                                       & slew_ctrl_ff[POS_RAMP_DOWN];
        conv_ctrl_out.pwm_forced       = mode_s2_ff;
        conv_ctrl_out.follow_ext_clock = sync_s2_ff;
    end

    // Assertions.
    // Lockout is a level, so the registers must sit at their reset values one edge later.
    a_undervoltage_lockout_reset: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        undervoltage_lockout_s2_ff |=> (ext_clock_ff == 8'h00 && slew_ctrl_ff == 8'h01))
        else $error("Lockout did not reset registers.");
    // A write that meets an active lockout must not land in the slew register.
    a_lockout_blocks: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (reg_wr_in.wr_en && reg_wr_in.addr == 8'h06 && undervoltage_lockout_s2_ff)
        |=> slew_ctrl_ff == 8'h01)
        else $error("Write landed during lockout.");
    // Reserved bits can never hold anything but their fixed values.
    a_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        ext_clock_ff[5:0] == 6'h00 && slew_ctrl_ff[2] == 1'b0)
        else $error("Reserved bits not zero.");
    a_bit0_one: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        slew_ctrl_ff[0] == 1'b1)
        else $error("Slew bit 0 not one.");
    // Power-save forcing only applies in automatic mode.
    a_pwm_ignores_ps: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        mode_s2_ff |-> !conv_ctrl_out.power_save_only)
        else $error("Power-save honoured in forced PWM.");
    a_psave_auto: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (!mode_s2_ff && slew_ctrl_ff[4]) |-> conv_ctrl_out.power_save_only)
        else $error("Power-save not forced in automatic mode.");
    // The oscillator stops in hysteretic operation unless the keep bit holds it up.
    a_osc_off: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (hys_s2_ff && !slew_ctrl_ff[3]) |-> !conv_ctrl_out.osc_on)
        else $error("Oscillator left on in hysteretic mode.");
    a_osc_kept: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (!hys_s2_ff || slew_ctrl_ff[3]) |-> conv_ctrl_out.osc_on)
        else $error("Oscillator stopped while it should run.");
    // The crossing detector may only be switched off under all four conditions at once.
    a_crossing_cond: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        conv_ctrl_out.crossing_det_off
        |-> (!mode_s2_ff && hys_s2_ff && down_s2_ff && slew_ctrl_ff[1]))
        else $error("Crossing detector off without cause.");
    a_crossing_on: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (!mode_s2_ff && hys_s2_ff && down_s2_ff && slew_ctrl_ff[1])
        |-> conv_ctrl_out.crossing_det_off)
        else $error("Crossing detector left on during ramp-down.");
    // Identification reads always give the fixed codes one edge after the address.
    a_id_read: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (rd_addr_in == 8'h08) |=> rd_data_out == DIE_KIND_VALUE)
        else $error("Die kind read wrong.");
    a_id_rev_read: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (rd_addr_in == 8'h09) |=> rd_data_out == DIE_REVISION_VALUE)
        else $error("Die revision read wrong.");
    // Writes aimed at the die kind code must leave every writable register alone.
    a_id_write_ignored: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (reg_wr_in.wr_en && reg_wr_in.addr == 8'h08 && !undervoltage_lockout_s2_ff)
        |=> $stable(ext_clock_ff) && $stable(slew_ctrl_ff))
        else $error("Identification write changed a register.");
    // Accepted writes are visible at the next edge.
    a_slew_write: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (reg_wr_in.wr_en && reg_wr_in.addr == 8'h06 && !undervoltage_lockout_s2_ff)
        |=> conv_ctrl_out.slew_code == $past(reg_wr_in.wdata[7:5]))
        else $error("Slew code not taken.");
    a_clock_write: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (reg_wr_in.wr_en && reg_wr_in.addr == 8'h05 && !undervoltage_lockout_s2_ff)
        |=> ext_clock_ff == ($past(reg_wr_in.wdata) & 8'hC0))
        else $error("Clock select not taken.");
    // Each selector code drives one frequency; both upper codes mean 19.2MHz.
    a_clk_code_26: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (ext_clock_ff[7:6] == 2'b00) |-> conv_ctrl_out.clk_freq == CLK_26MHZ)
        else $error("Clock code 0 decoded wrong.");
    a_clk_code_13: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (ext_clock_ff[7:6] == 2'b01) |-> conv_ctrl_out.clk_freq == CLK_13MHZ)
        else $error("Clock code 1 decoded wrong.");
    a_clk_code_19m2: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        ext_clock_ff[7] |-> conv_ctrl_out.clk_freq == CLK_19M2HZ)
        else $error("Upper clock codes decoded wrong.");
    // Mode levels reach the converter after the two synchroniser stages.
    a_pwm_follows: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        conv_ctrl_out.pwm_forced == $past(operation_mode_in, 2))
        else $error("Forced PWM flag does not track the mode bit.");
    a_sync_follows: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        conv_ctrl_out.follow_ext_clock == $past(ext_clock_follow_enable_in, 2))
        else $error("Clock follow flag does not track its enable.");
    // Main scenarios worth seeing at least once.
    c_lockout: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) $fell(undervoltage_lockout_s2_ff));
    c_clk_19m2: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        conv_ctrl_out.clk_freq == CLK_19M2HZ);
    c_ramp_down: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        conv_ctrl_out.crossing_det_off);
    c_pwm_forced: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        conv_ctrl_out.pwm_forced && slew_ctrl_ff[4]);
    c_osc_kept: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        hys_s2_ff && conv_ctrl_out.osc_on);
endmodule
`default_nettype wire

// file: host_model.sv
// Host-side model that issues register writes and reads on the register port.
`timescale 1ns/100ps
`default_nettype none
module host_model
    import ramp_id_pkg::*;
(
    // Clock and read answer.
    input  wire logic            clk_sys_in,
    input  wire logic [7:0]      rd_data_in,
    // Requests toward the bank.
    output ramp_id_pkg::reg_wr_t reg_wr_out,
    output logic [7:0]           rd_addr_out
);
    // Idle request at time zero.
    initial begin
        reg_wr_out = '0;
        rd_addr_out = 8'h00;
    end
    // One-cycle write pulse; released fields show inverted values.
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_wr_out <= '{wr_en: 1'b1, addr: a, wdata: d};
        @(posedge clk_sys_in);
        reg_wr_out <= '{wr_en: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // Read whose answer is settled one edge after the address.
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        rd_addr_out <= a;
        repeat (2) @(posedge clk_sys_in);
        #1 d = rd_data_in;
    endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the clock-select, slew and identification registers.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ramp_id_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic [1:0] f;} row_t;
    logic       clk_sys_in, arst_n_in, uv_vdd, uv_main, hyst, rdown, opmode, follow;
    reg_wr_t    wr;
    logic [7:0] rd_addr, rd_data, q;
    conv_ctrl_t ctrl;
    int         failures = 0, checks_done = 0, cycles = 0;
    row_t rows[9] = '{'{8'h05, 8'hFF, 8'hC0, 2'd2}, '{8'h05, 8'h00, 8'h00, 2'd0},
        '{8'h05, 8'h7F, 8'h40, 2'd1}, '{8'h05, 8'h80, 8'h80, 2'd2},
        '{8'h06, 8'hFF, 8'hFB, 2'd0}, '{8'h06, 8'hE2, 8'hE3, 2'd0},
        '{8'h08, 8'h00, 8'h37, 2'd0}, '{8'h09, 8'hFF, 8'h1C, 2'd0},
        '{8'h07, 8'h55, 8'h00, 2'd0}};
    regulator_sync_ramp_id_regs regulator_sync_ramp_id_regs_inst (.clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in), .vdd_undervoltage_lockout_in(uv_vdd),
        .main_input_supply_undervoltage_lockout_in(uv_main), .reg_wr_in(wr),
        .rd_addr_in(rd_addr), .rd_data_out(rd_data), .hysteretic_active_in(hyst),
        .ramping_down_in(rdown), .operation_mode_in(opmode),
        .ext_clock_follow_enable_in(follow), .conv_ctrl_out(ctrl));
    host_model host_model_inst (.clk_sys_in(clk_sys_in), .rd_data_in(rd_data),
        .reg_wr_out(wr), .rd_addr_out(rd_addr));
    // Free-running 100 MHz clock.
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // Cuts a hang short.
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            summarize();
        end
    end
    // Compares one value.
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // Prints counts and verdict, then stops.
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Main sequence.
    initial begin
        {uv_vdd, uv_main, hyst, rdown, opmode, follow} = 6'h00;
        arst_n_in = 1'b0;
        repeat (20) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        host_model_inst.read(OFS_EXT_CLOCK, q);
        chk("clock reset", 8'h00, q);
        host_model_inst.read(OFS_SLEW_CTRL, q);
        chk("slew reset", 8'h01, q);
        $display("reset test done");
        foreach (rows[i]) begin
            host_model_inst.write(rows[i].a, rows[i].d);
            host_model_inst.read(rows[i].a, q);
            chk("readback", rows[i].q, q);
            if (rows[i].a == 8'h05) chk("freq", {6'h00, rows[i].f}, {6'h00, ctrl.clk_freq});
            if (rows[i].a == 8'h06) chk("slew", {5'h00, rows[i].d[7:5]}, {5'h00, ctrl.slew_code});
        end
        $display("table test done");
        host_model_inst.write(OFS_SLEW_CTRL, 8'h1B);
        {hyst, rdown, follow, opmode} <= 4'b1110;
        repeat (4) @(posedge clk_sys_in);
        #1 chk("psave", 8'h01, {7'h00, ctrl.power_save_only});
        chk("osc", 8'h01, {7'h00, ctrl.osc_on});
        chk("crossing", 8'h01, {7'h00, ctrl.crossing_det_off});
        chk("follow", 8'h01, {7'h00, ctrl.follow_ext_clock});
        @(posedge clk_sys_in) {opmode, follow} <= 2'b10;
        repeat (4) @(posedge clk_sys_in);
        #1 chk("psave pwm", 8'h00, {7'h00, ctrl.power_save_only});
        chk("pwm", 8'h01, {7'h00, ctrl.pwm_forced});
        chk("crossing pwm", 8'h00, {7'h00, ctrl.crossing_det_off});
        chk("follow off", 8'h00, {7'h00, ctrl.follow_ext_clock});
        @(posedge clk_sys_in) opmode <= 1'b0;
        host_model_inst.write(OFS_SLEW_CTRL, 8'h01);
        repeat (4) @(posedge clk_sys_in);
        #1 chk("osc off", 8'h00, {7'h00, ctrl.osc_on});
        chk("psave auto", 8'h00, {7'h00, ctrl.power_save_only});
        $display("mode test done");
        for (int s = 0; s < 2; s++) begin
            host_model_inst.write(OFS_SLEW_CTRL, 8'hE2);
            @(posedge clk_sys_in) {uv_vdd, uv_main} <= (s == 0) ? 2'b10 : 2'b01;
            repeat (4) @(posedge clk_sys_in);
            host_model_inst.write(OFS_SLEW_CTRL, 8'hFF);
            @(posedge clk_sys_in) {uv_vdd, uv_main} <= 2'b00;
            repeat (3) @(posedge clk_sys_in);
            host_model_inst.read(OFS_SLEW_CTRL, q);
            chk("lockout slew", 8'h01, q);
        end
        host_model_inst.read(OFS_EXT_CLOCK, q);
        chk("lockout clock", 8'h00, q);
        $display("lockout test done");
        summarize();
    end
endmodule
`default_nettype wire
